/* logic/fsp_pin_if.sv */
// pin-side interface control of a serial flash slave
// assumes the spi pins are asynchronous to i_clk and that sck runs well below i_clk / 4
`default_nettype none
// Overview of operation
// R1 - chip select falling starts, rising ends frame
// R2 - deselected: outputs released, input data ignored
// R3 - deselect gives standby unless program/erase busy
// R4 - host data sampled on sck rising edge
// R5 - output data changes on sck falling edge
// R6 - multi-lane reads turn lane 0 into output
// R7 - guard pin low blocks status writes
// R8 - four-lane enable turns guard pin into lane_two
// R9 - 256-byte page buffer before 4 Mbit array
// R10 - lane_three is pause, reset or data
// R11 - pause with sck low keeps clocking state
// R12 - counters cleared on every deselect
module fsp_pin_if
  import fsp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // spi pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_lane_in,
  output logic [3:0] o_lane_out,
  output logic [3:0] o_lane_oe_n,
  // configuration
  input wire logic i_four_lane_enable,
  input wire logic i_register_guard_upper,
  input wire logic i_register_guard_lower,
  input wire logic i_pause_reset_sel,
  input wire fsp_mode_t i_lane_mode,
  input wire logic i_out_enable,
  input wire logic i_busy,
  // received bytes
  output logic o_rx_valid,
  output fsp_byte_t o_rx_byte,
  input wire logic i_rx_ready,
  output logic o_rx_overrun,
  // bytes to send
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // page buffer read port
  input wire logic [7:0] i_page_rd_addr,
  output logic [7:0] o_page_rd_data,
  // status
  output logic o_selected,
  output logic o_standby,
  output logic o_paused,
  output logic o_status_write_blocked,
  output logic o_hw_reset_req
);
  // ***********************************************************************
  // helpers
  // ***********************************************************************
  // bits moved per sck edge; quad only counts with four-lane enable set
  function automatic logic [3:0] lane_width(input fsp_mode_t mode, input logic qe);
    logic [3:0] w;
    w = 4'h1;
    case (mode)
      FSP_MODE_DUAL: w = 4'h2;
      FSP_MODE_QUAD: w = qe ? 4'h4 : 4'h1; // R8
      default: w = 4'h1;
    endcase
    return w;
  endfunction : lane_width

  // ***********************************************************************
  // pin synchronisers
  // ***********************************************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pins_raw, s1_r, s2_r, s1_nxt, s2_nxt;
  logic cs_n_s, sck_s, sck_d_r, sck_d_nxt;
  logic [3:0] lane_s;
  logic sck_rise, sck_fall;

  assign pins_raw = {i_cs_n, i_sck, i_lane_in};
  assign cs_n_s = s2_r[5];
  assign sck_s = s2_r[4];
  assign lane_s = s2_r[3:0];

  always_comb begin
    s1_nxt = pins_raw;
    s2_nxt = s1_r;
    sck_d_nxt = sck_s;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_r <= {2'h2, 4'hf};
      s2_r <= {2'h2, 4'hf};
      sck_d_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      sck_d_r <= sck_d_nxt;
    end
  end

  assign sck_rise = sck_s && !sck_d_r;
  assign sck_fall = !sck_s && sck_d_r;

  // ***********************************************************************
  // lane three function
  // ***********************************************************************
  logic pause_fn, reset_fn, hold_d_r, hold_d_nxt;
  logic hold_fall, hold_rise;

  assign pause_fn = !i_four_lane_enable && !i_pause_reset_sel; // R10
  assign reset_fn = !i_four_lane_enable && i_pause_reset_sel; // R10
  assign hold_fall = !lane_s[FSP_L3] && hold_d_r;
  assign hold_rise = lane_s[FSP_L3] && !hold_d_r;

  always_comb begin
    hold_d_nxt = lane_s[FSP_L3];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_d_r <= 1'b1;
    end else begin
      hold_d_r <= hold_d_nxt;
    end
  end

  // ***********************************************************************
  // frame state
  // ***********************************************************************
  fsp_state_t st_r, st_nxt;
  logic active, reset_pin;

  assign reset_pin = reset_fn && !lane_s[FSP_L3]; // R10

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FSP_ST_IDLE: begin
        if (!cs_n_s && !reset_pin) begin
          st_nxt = FSP_ST_ACTIVE; // R1
        end
      end
      FSP_ST_ACTIVE: begin
        if (pause_fn && hold_fall && !sck_s) begin
          st_nxt = FSP_ST_PAUSED; // R11
        end
      end
      FSP_ST_PAUSED: begin
        if (hold_rise && !sck_s) begin
          st_nxt = FSP_ST_ACTIVE; // R11
        end
      end
      default: st_nxt = FSP_ST_IDLE;
    endcase
    if (cs_n_s || reset_pin) begin
      st_nxt = FSP_ST_IDLE; // R1
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= FSP_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // sck edges count only inside an unpaused frame
  assign active = (st_r == FSP_ST_ACTIVE) && !cs_n_s; // R2

  // ***********************************************************************
  // receive shifter
  // ***********************************************************************
  logic [3:0] rx_w, tx_w;
  logic [7:0] rx_sr_r, rx_sr_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt;
  logic rx_first_r, rx_first_nxt;
  logic [7:0] in_bits, rx_shifted;
  logic [3:0] rx_sum;
  logic fifo_in_valid, fifo_in_ready;
  fsp_byte_t fifo_in_byte;
  logic ovr_r, ovr_nxt;
  logic [7:0] pg_wp_r, pg_wp_nxt;
  logic pg_we;

  assign rx_w = lane_width(i_lane_mode, i_four_lane_enable);
  assign tx_w = lane_width(i_lane_mode, i_four_lane_enable);

  always_comb begin
    in_bits = {7'h00, lane_s[FSP_L0]};
    case (rx_w)
      4'h2: in_bits = {6'h00, lane_s[FSP_L1], lane_s[FSP_L0]};
      4'h4: in_bits = {4'h0, lane_s};
      default: in_bits = {7'h00, lane_s[FSP_L0]};
    endcase
    rx_shifted = (rx_sr_r << rx_w) | in_bits;
    rx_sum = rx_cnt_r + rx_w;
  end

  always_comb begin
    rx_sr_nxt = rx_sr_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_first_nxt = rx_first_r;
    ovr_nxt = ovr_r;
    pg_wp_nxt = pg_wp_r;
    fifo_in_valid = 1'b0;
    fifo_in_byte = '{first: rx_first_r, data: rx_shifted};
    pg_we = 1'b0;
    if (active && sck_rise && !i_out_enable) begin
      rx_sr_nxt = rx_shifted; // R4
      rx_cnt_nxt = rx_sum;
      if (rx_sum >= FSP_CNT_FULL) begin
        rx_cnt_nxt = 4'h0;
        rx_first_nxt = 1'b0;
        fifo_in_valid = 1'b1;
        if (!fifo_in_ready) begin
          ovr_nxt = 1'b1;
        end
        if (!rx_first_r) begin
          pg_we = 1'b1; // R9
          pg_wp_nxt = pg_wp_r + 8'h01;
        end
      end
    end
    if (cs_n_s) begin
      rx_cnt_nxt = 4'h0; // R12
      rx_first_nxt = 1'b1; // R12
      pg_wp_nxt = 8'h00; // R12
    end
    if (st_r == FSP_ST_IDLE && !cs_n_s) begin
      ovr_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_sr_r <= 8'h00;
      rx_cnt_r <= 4'h0;
      rx_first_r <= 1'b1;
      ovr_r <= 1'b0;
      pg_wp_r <= 8'h00;
    end else begin
      rx_sr_r <= rx_sr_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_first_r <= rx_first_nxt;
      ovr_r <= ovr_nxt;
      pg_wp_r <= pg_wp_nxt;
    end
  end

  fsp_fifo #(
    .WIDTH(FSP_BYTE_W),
    .DEPTH(FSP_FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_valid(fifo_in_valid),
    .i_in_data(fifo_in_byte),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_byte),
    .i_out_ready(i_rx_ready)
  );

  assign o_rx_overrun = ovr_r;

  // ***********************************************************************
  // page buffer
  // ***********************************************************************
  logic [7:0] page_mem [FSP_PAGE_BYTES];
  logic [7:0] pg_rd_r;

  always_ff @(posedge i_clk) begin
    if (pg_we) begin
      page_mem[pg_wp_r] <= rx_shifted; // R9
    end
    pg_rd_r <= page_mem[i_page_rd_addr];
  end

  assign o_page_rd_data = pg_rd_r;

  // ***********************************************************************
  // transmit shifter
  // ***********************************************************************
  logic [7:0] tx_sr_r, tx_sr_nxt, tx_byte;
  logic [3:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0] out_r, out_nxt, oe_n_r, oe_n_nxt;
  logic tx_take;

  assign tx_take = active && sck_fall && i_out_enable && (tx_cnt_r == 4'h0);
  assign o_tx_ready = tx_take;

  always_comb begin
    tx_byte = tx_sr_r;
    if (tx_cnt_r == 4'h0) begin
      tx_byte = i_tx_valid ? i_tx_data : FSP_IDLE_BYTE;
    end
  end

  always_comb begin
    tx_sr_nxt = tx_sr_r;
    tx_cnt_nxt = tx_cnt_r;
    out_nxt = out_r;
    if (active && sck_fall && i_out_enable) begin
      tx_sr_nxt = tx_byte << tx_w; // R5
      tx_cnt_nxt = ((tx_cnt_r == 4'h0) ? FSP_CNT_FULL : tx_cnt_r) - tx_w;
      case (tx_w)
        4'h2: out_nxt = {2'h3, tx_byte[7], tx_byte[6]}; // R6
        4'h4: out_nxt = tx_byte[7:4]; // R6
        default: out_nxt = {2'h3, tx_byte[7], 1'b1};
      endcase
    end
    if (cs_n_s) begin
      tx_cnt_nxt = 4'h0; // R12
    end
  end

  // lanes driven only while selected, unpaused and in the data phase
  logic [3:0] drive_mask;
  always_comb begin
    drive_mask = 4'h0;
    if (active && i_out_enable) begin
      drive_mask[FSP_L1] = 1'b1; // R5
      drive_mask[FSP_L0] = (tx_w != 4'h1); // R6
      drive_mask[FSP_L2] = (tx_w == 4'h4); // R8
      drive_mask[FSP_L3] = (tx_w == 4'h4); // R10
    end
  end

  genvar g;
  generate
    for (g = 0; g < FSP_LANES; g++) begin : g_oe
      assign oe_n_nxt[g] = !drive_mask[g]; // R2
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_sr_r <= 8'h00;
      tx_cnt_r <= 4'h0;
      out_r <= 4'hf;
      oe_n_r <= FSP_OE_OFF;
    end else begin
      tx_sr_r <= tx_sr_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign o_lane_out = out_r;
  assign o_lane_oe_n = oe_n_r;

  // ***********************************************************************
  // status outputs
  // ***********************************************************************
  logic blk_r, blk_nxt, stby_r, stby_nxt, hwr_r, hwr_nxt;

  always_comb begin
    blk_nxt = !i_four_lane_enable && !i_register_guard_upper && i_register_guard_lower
              && !lane_s[FSP_L2]; // R7
    stby_nxt = cs_n_s && !i_busy; // R3
    hwr_nxt = reset_pin; // R10
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      blk_r <= 1'b0;
      stby_r <= 1'b1;
      hwr_r <= 1'b0;
    end else begin
      blk_r <= blk_nxt;
      stby_r <= stby_nxt;
      hwr_r <= hwr_nxt;
    end
  end

  assign o_status_write_blocked = blk_r;
  assign o_standby = stby_r;
  assign o_hw_reset_req = hwr_r;
  assign o_selected = (st_r != FSP_ST_IDLE);
  assign o_paused = (st_r == FSP_ST_PAUSED);
endmodule : fsp_pin_if
`default_nettype wire

/* logic/fsp_pkg.sv */
// package of the serial flash pin interface: constants, modes, states, carriers
// assumes nothing of its surroundings
`default_nettype none
package fsp_pkg;
  // ***********************************************************************
  // sizes
  // ***********************************************************************
  localparam int FSP_BYTE_BITS = 8;
  localparam int FSP_PAGE_BYTES = 256;
  localparam int FSP_PAGE_AW = 8;
  localparam int FSP_ARRAY_BITS = 4 * 1024 * 1024;
  localparam int FSP_FIFO_DEPTH = 32;
  localparam int FSP_LANES = 4;
  localparam logic [3:0] FSP_CNT_FULL = 4'h8;
  localparam logic [7:0] FSP_IDLE_BYTE = 8'hff;
  localparam logic [3:0] FSP_OE_OFF = 4'hf;
  // ***********************************************************************
  // lane positions
  // ***********************************************************************
  localparam int FSP_L0 = 0;
  localparam int FSP_L1 = 1;
  localparam int FSP_L2 = 2;
  localparam int FSP_L3 = 3;
  // ***********************************************************************
  // types
  // ***********************************************************************
  typedef enum logic [1:0] {
    FSP_MODE_SINGLE = 2'h0,
    FSP_MODE_DUAL = 2'h1,
    FSP_MODE_QUAD = 2'h2
  } fsp_mode_t;

  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'h0,
    FSP_ST_ACTIVE = 2'h1,
    FSP_ST_PAUSED = 2'h3
  } fsp_state_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } fsp_byte_t;

  localparam int FSP_BYTE_W = $bits(fsp_byte_t);
endpackage : fsp_pkg
`default_nettype wire

/* logic/fsp_fifo.sv */
// synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active high reset
`default_nettype none
module fsp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign o_in_ready = (cnt_r != DEPTH_C);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem[rd_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = (wr_r == LAST_C) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST_C) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_r] <= i_in_data;
    end
  end
endmodule : fsp_fifo
`default_nettype wire

/* verification/fsp_chk.sv */
// checker of the flash pin interface, seeing only its ports
// assumes binding to fsp_pin_if, one clock domain
`default_nettype none
module fsp_chk
  import fsp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pins and configuration
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_lane_in,
  input wire logic [3:0] o_lane_oe_n,
  input wire logic i_four_lane_enable,
  input wire logic i_register_guard_upper,
  input wire logic i_register_guard_lower,
  input wire logic i_pause_reset_sel,
  input wire fsp_mode_t i_lane_mode,
  input wire logic i_out_enable,
  input wire logic i_busy,
  // data and status
  input wire logic o_rx_valid,
  input wire fsp_byte_t o_rx_byte,
  input wire logic i_rx_ready,
  input wire logic o_rx_overrun,
  input wire logic o_tx_ready,
  input wire logic o_selected,
  input wire logic o_standby,
  input wire logic o_paused,
  input wire logic o_status_write_blocked,
  input wire logic o_hw_reset_req
);
  logic [3:0] oe_exp;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // lanes the width in force should drive
  assign oe_exp = (i_lane_mode == FSP_MODE_DUAL) ? 4'hc :
    (i_lane_mode == FSP_MODE_QUAD && i_four_lane_enable) ? 4'h0 : 4'hd;
  // ****
  // properties
  // ****
  property p_desel_rel;
    !o_selected [*2] |-> o_lane_oe_n == FSP_OE_OFF;
  endproperty
  a_desel_rel: assert property (p_desel_rel) else $error("lanes driven off frame");
  property p_sel_start;
    $fell(i_cs_n) && !o_hw_reset_req |-> ##[1:6] o_selected;
  endproperty
  a_sel_start: assert property (p_sel_start) else $error("frame not started");
  property p_sel_end;
    $rose(i_cs_n) |-> ##[1:6] !o_selected;
  endproperty
  a_sel_end: assert property (p_sel_end) else $error("frame not ended");
  property p_standby;
    i_cs_n [*4] |=> o_standby == !$past(i_busy);
  endproperty
  a_standby: assert property (p_standby) else $error("standby wrong");
  property p_guard;
    (!i_four_lane_enable && !i_register_guard_upper && i_register_guard_lower
      && !i_lane_in[2]) [*4] |=> o_status_write_blocked;
  endproperty
  a_guard: assert property (p_guard) else $error("guard not blocking");
  property p_quad_pins;
    i_four_lane_enable |=> !o_status_write_blocked && !o_hw_reset_req;
  endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("lane pins misused");
  property p_hw_rst;
    (!i_four_lane_enable && i_pause_reset_sel && !i_lane_in[3]) [*4] |=> o_hw_reset_req;
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("reset pin ignored");
  property p_pause_fn;
    $rose(o_paused) |-> !$past(i_four_lane_enable) && !$past(i_pause_reset_sel)
      && !$past(i_sck, 3);
  endproperty
  a_pause_fn: assert property (p_pause_fn) else $error("pause out of place");
  property p_pause_rel;
    o_paused [*2] |-> o_lane_oe_n == FSP_OE_OFF;
  endproperty
  a_pause_rel: assert property (p_pause_rel) else $error("lanes driven in pause");
  property p_tx_lanes;
    o_tx_ready && i_out_enable |=> o_lane_oe_n == $past(oe_exp);
  endproperty
  a_tx_lanes: assert property (p_tx_lanes) else $error("wrong lanes driven");
  property p_rx_hold;
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_byte);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("byte lost");
  c_paused: cover property (o_paused);
  c_overrun: cover property (o_rx_overrun);
  c_quad_tx: cover property (o_tx_ready && i_lane_mode == FSP_MODE_QUAD);
endmodule : fsp_chk
bind fsp_pin_if fsp_chk i_fsp_chk (
  .i_clk, .i_reset, .i_cs_n, .i_sck, .i_lane_in, .o_lane_oe_n, .i_four_lane_enable,
  .i_register_guard_upper, .i_register_guard_lower, .i_pause_reset_sel, .i_lane_mode,
  .i_out_enable, .i_busy, .o_rx_valid, .o_rx_byte, .i_rx_ready, .o_rx_overrun,
  .o_tx_ready, .o_selected, .o_standby, .o_paused, .o_status_write_blocked, .o_hw_reset_req
);
`default_nettype wire

/* verification/fsp_host.sv */
// host side of the spi link: chip select, serial clock, lanes
// assumes the bench resolves each lane, released lanes pull high
`default_nettype none
module fsp_host (
  // link pins
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_d,
  output logic [3:0] o_en,
  input wire logic [3:0] i_lane
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_d = 4'hf;
    o_en = 4'h0;
  end
  task automatic cs(input logic v);
    #48 o_cs_n = v;
    #48;
  endtask : cs
  // bits go out while the clock is low, msb first
  task automatic put(input logic [7:0] b, input int w, input int n);
    for (int i = 0; i < n; i++) begin
      o_en = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
      o_d = (w == 4) ? b[7:4] : (w == 2) ? {2'h3, b[7:6]} : {3'h7, b[7]};
      b = b << w;
      #24 o_sck = 1'b1;
      #24 o_sck = 1'b0;
    end
    o_en = 4'h0;
  endtask : put
  // each falling edge launches a unit, taken at the next rise
  task automatic get(input int w, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      o_sck = 1'b1;
      #24 o_sck = 1'b0;
      #24;
      b = (w == 4) ? {b[3:0], i_lane} : (w == 2) ? {b[5:0], i_lane[1:0]} : {b[6:0], i_lane[1]};
    end
  endtask : get
  // low drives the pin, high releases it to its pull-up
  task automatic pin(input int i, input logic v);
    o_en[i] = !v;
    o_d[i] = v;
    #48;
  endtask : pin
endmodule : fsp_host
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench of the flash pin interface
// assumes fsp_host as the link partner, checker bound separately
`default_nettype none
module tb_top
  import fsp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset, i_cs_n, i_sck, i_rx_ready, i_four_lane_enable, i_register_guard_upper;
  logic i_register_guard_lower, i_pause_reset_sel, i_out_enable, i_busy, i_tx_valid;
  logic o_rx_valid, o_rx_overrun, o_tx_ready, o_selected, o_standby, o_paused;
  logic o_status_write_blocked, o_hw_reset_req;
  logic [3:0] o_lane_out, o_lane_oe_n, h_d, h_en, lane_w;
  logic [7:0] i_tx_data, i_page_rd_addr, o_page_rd_data, rb;
  fsp_mode_t i_lane_mode;
  fsp_byte_t o_rx_byte;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int tx_seen = 0;
  // lane level from both parties, pull-up when nobody drives
  assign lane_w = (~o_lane_oe_n & o_lane_out) | (o_lane_oe_n & ~h_en) | (o_lane_oe_n & h_d);
  fsp_pin_if i_fsp_pin_if (
    .i_clk, .i_reset, .i_cs_n, .i_sck, .i_lane_in(lane_w), .o_lane_out, .o_lane_oe_n,
    .i_four_lane_enable, .i_register_guard_upper, .i_register_guard_lower,
    .i_pause_reset_sel, .i_lane_mode, .i_out_enable, .i_busy, .o_rx_valid, .o_rx_byte,
    .i_rx_ready, .o_rx_overrun, .i_tx_valid, .i_tx_data, .o_tx_ready, .i_page_rd_addr,
    .o_page_rd_data, .o_selected, .o_standby, .o_paused, .o_status_write_blocked,
    .o_hw_reset_req
  );
  fsp_host i_fsp_host (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_d(h_d), .o_en(h_en), .i_lane(lane_w));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic frame(input logic [7:0] b, input int w);
    i_fsp_host.cs(1'b0);
    i_fsp_host.put(b, w, 8 / w);
    i_fsp_host.cs(1'b1);
  endtask : frame
  task automatic take(input logic [8:0] exp);
    @(negedge i_clk);
    for (int k = 0; k < 100 && o_rx_valid !== 1'b1; k++) @(negedge i_clk);
    chk({o_rx_valid, o_rx_byte}, {1'b1, exp});
    i_rx_ready = 1'b1;
    @(negedge i_clk) i_rx_ready = 1'b0;
  endtask : take
  // whole run is near 5000 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  always @(posedge i_clk) begin
    if (o_tx_ready === 1'b1) begin
      tx_seen <= tx_seen + 1;
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    i_reset = 1'b1;
    {i_rx_ready, i_four_lane_enable, i_register_guard_upper, i_register_guard_lower} = 4'h0;
    {i_pause_reset_sel, i_out_enable, i_busy, i_tx_valid} = 4'h0;
    i_lane_mode = FSP_MODE_SINGLE;
    i_tx_data = 8'h00;
    i_page_rd_addr = 8'h00;
    repeat (3) @(negedge i_clk);
    i_reset = 1'b0;
    chk({o_lane_oe_n, o_standby, o_selected, o_rx_valid, o_hw_reset_req}, 8'hf8);
    i_busy = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_standby, 1'b0);
    i_busy = 1'b0;
    i_fsp_host.cs(1'b0);
    i_fsp_host.put(8'ha5, 1, 8);
    i_fsp_host.put(8'h3c, 1, 8);
    i_fsp_host.cs(1'b1);
    take(9'h1a5);
    take(9'h03c);
    chk(o_page_rd_data, 8'h3c);
    i_fsp_host.put(8'h00, 1, 8);
    i_fsp_host.cs(1'b0);
    i_fsp_host.put(8'hf0, 1, 4);
    i_fsp_host.cs(1'b1);
    chk(o_rx_valid, 1'b0);
    frame(8'h81, 1);
    take(9'h181);
    @(negedge i_clk) i_lane_mode = FSP_MODE_QUAD;
    frame(8'hc3, 1);
    take(9'h1c3);
    i_four_lane_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clk) i_lane_mode = fsp_mode_t'(k);
      frame(8'h5a + 8'(k), 1 << k);
      take({1'b1, 8'h5a + 8'(k)});
    end
    {i_out_enable, i_tx_valid, i_tx_data} = {2'h3, 8'h96};
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clk) i_lane_mode = fsp_mode_t'(k);
      i_fsp_host.cs(1'b0);
      i_fsp_host.get(1 << k, rb);
      i_fsp_host.cs(1'b1);
      chk({o_rx_valid, rb}, 9'h096);
    end
    @(negedge i_clk) i_tx_valid = 1'b0;
    i_lane_mode = FSP_MODE_SINGLE;
    i_fsp_host.cs(1'b0);
    i_fsp_host.get(1, rb);
    i_fsp_host.cs(1'b1);
    chk({tx_seen[7:0], rb}, 16'h04ff);
    @(negedge i_clk) {i_out_enable, i_four_lane_enable, i_register_guard_lower} = 3'h1;
    i_lane_mode = FSP_MODE_SINGLE;
    i_fsp_host.pin(2, 1'b0);
    chk(o_status_write_blocked, 1'b1);
    i_register_guard_upper = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_status_write_blocked, 1'b0);
    {i_register_guard_upper, i_four_lane_enable} = 2'h1;
    repeat (3) @(negedge i_clk);
    chk(o_status_write_blocked, 1'b0);
    i_fsp_host.pin(2, 1'b1);
    {i_four_lane_enable, i_pause_reset_sel} = 2'h1;
    i_fsp_host.pin(3, 1'b0);
    chk({o_hw_reset_req, o_selected}, 2'h2);
    i_fsp_host.pin(3, 1'b1);
    i_pause_reset_sel = 1'b0;
    i_fsp_host.cs(1'b0);
    i_fsp_host.put(8'he7, 1, 4);
    i_fsp_host.pin(3, 1'b0);
    chk({o_paused, o_lane_oe_n}, 5'h1f);
    i_fsp_host.pin(3, 1'b1);
    i_fsp_host.put(8'h70, 1, 4);
    i_fsp_host.cs(1'b1);
    take(9'h1e7);
    i_fsp_host.cs(1'b0);
    for (int k = 0; k < 33; k++) i_fsp_host.put(8'(k), 1, 8);
    i_fsp_host.cs(1'b1);
    @(negedge i_clk) i_page_rd_addr = 8'h1e;
    repeat (2) @(negedge i_clk);
    chk({o_rx_overrun, o_rx_byte, o_page_rd_data}, {1'b1, 9'h100, 8'h1f});
    i_rx_ready = 1'b1;
    for (n = 0; n < 40 && o_rx_valid === 1'b1; n++) @(negedge i_clk);
    i_rx_ready = 1'b0;
    chk(n, 32);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
